/* File: logic/drive_power_state_machine.sv */
`timescale 1ns/1ns
`default_nettype none
module drive_power_state_machine
	import drive_power_pkg::*;
(
	input  wire logic        CLOCK,
	input  wire logic        SYS_RST,
	input  wire logic        OBJ_WR,
	input  wire logic        OBJ_RD,
	input  wire logic [15:0] OBJ_INDEX,
	input  wire logic [15:0] OBJ_WDATA,
	input  wire logic        SELF_TEST_DONE,
	input  wire logic        SELF_TEST_OK,
	input  wire logic        FAULT_EVENT,
	input  wire logic        FATAL_ERROR,
	output logic      [15:0] OBJ_RDATA,
	output logic             OBJ_RVALID,
	output logic             OBJ_ERR,
	output logic      [15:0] POWER_STATE_WORD,
	output logic      [7:0]  ACTIVE_MODE,
	output logic             POWER_STAGE_ON
);
	import drive_power_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [PIN_COUNT-1:0] pin_meta;
	logic [PIN_COUNT-1:0] pin_sync;
	logic [PIN_COUNT-1:0] pin_raw;

	assign pin_raw = {FATAL_ERROR, FAULT_EVENT, SELF_TEST_OK, SELF_TEST_DONE};

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
		end
	end

	logic test_done;
	logic test_ok;
	logic fault_in;
	logic fatal_in;
	assign test_done = pin_sync[PIN_TEST_DONE];
	assign test_ok   = pin_sync[PIN_TEST_OK];
	assign fault_in  = pin_sync[PIN_FAULT];
	assign fatal_in  = pin_sync[PIN_FATAL];

	////////////////////////////////////////////////////////////////////
	// Object storage
	logic [15:0] command_word;
	logic [15:0] command_prev;
	logic [7:0]  mode_request;
	logic [15:0] next_command_word;
	logic [7:0]  next_mode_request;
	logic [7:0]  next_active_mode;

	always_comb begin
		next_command_word = command_word;
		next_mode_request = mode_request;
		if (OBJ_WR && OBJ_INDEX == IDX_COMMAND_WORD)
			next_command_word = OBJ_WDATA;
		// No state check: mode may change at any time
		if (OBJ_WR && OBJ_INDEX == IDX_MODE_SELECT)
			next_mode_request = OBJ_WDATA[7:0];
		next_active_mode = mode_request;
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			command_word <= COMMAND_RESET;
			command_prev <= COMMAND_RESET;
			mode_request <= MODE_RESET;
			ACTIVE_MODE  <= MODE_RESET;
		end else begin
			command_word <= next_command_word;
			command_prev <= command_word;
			mode_request <= next_mode_request;
			ACTIVE_MODE  <= next_active_mode;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Command decode; bits not listed here are never looked at
	logic b7;
	logic b3;
	logic b2;
	logic b1;
	logic b0;
	logic cmd_shutdown;
	logic cmd_switch_on;
	logic cmd_disable_voltage;
	logic cmd_quick_stop;
	logic cmd_enable_op;
	logic fault_reset_edge;
	logic quick_stop_release;

	assign b7 = command_word[CMD_FAULT_RESET];
	assign b3 = command_word[CMD_ENABLE_OP];
	assign b2 = command_word[CMD_QUICK_STOP];
	assign b1 = command_word[CMD_VOLTAGE];
	assign b0 = command_word[CMD_SWITCH_ON];

	assign cmd_shutdown        = !b7 && b2 && b1 && !b0;
	assign cmd_switch_on       = !b7 && !b3 && b2 && b1 && b0;
	assign cmd_enable_op       = !b7 && b3 && b2 && b1 && b0;
	assign cmd_disable_voltage = !b7 && !b1;
	assign cmd_quick_stop      = !b7 && !b2 && b1;
	// Edges only, so a held bit cannot retrigger
	assign fault_reset_edge = b7 && !command_prev[CMD_FAULT_RESET];
	assign quick_stop_release = !b7 && b3 && b1 && b0 && b2
		&& !command_prev[CMD_QUICK_STOP];

	////////////////////////////////////////////////////////////////////
	// Power state machine
	power_state_e state;
	power_state_e next_state;
	logic [15:0]  next_state_word;

	always_comb begin
		next_state = state;
		case (state)
			ST_SELF_TEST:
				if (test_done)
					next_state = test_ok ? ST_SWITCH_ON_DISABLED
						: ST_NOT_READY;
			ST_NOT_READY:
				next_state = ST_NOT_READY;
			ST_SWITCH_ON_DISABLED:
				if (cmd_shutdown)
					next_state = ST_READY;
			ST_READY:
				if (cmd_disable_voltage)
					next_state = ST_SWITCH_ON_DISABLED;
				else if (cmd_switch_on)
					next_state = ST_SWITCHED_ON;
			ST_SWITCHED_ON:
				if (cmd_disable_voltage)
					next_state = ST_SWITCH_ON_DISABLED;
				else if (cmd_shutdown)
					next_state = ST_READY;
				else if (cmd_enable_op)
					next_state = ST_OP_ENABLED;
			ST_OP_ENABLED:
				if (cmd_disable_voltage)
					next_state = ST_SWITCH_ON_DISABLED;
				else if (cmd_quick_stop)
					next_state = ST_QUICK_STOP;
				else if (cmd_shutdown)
					next_state = ST_READY;
				else if (cmd_switch_on)
					next_state = ST_SWITCHED_ON;
			ST_QUICK_STOP:
				if (cmd_disable_voltage)
					next_state = ST_SWITCH_ON_DISABLED;
				else if (quick_stop_release)
					next_state = ST_OP_ENABLED;
			// Braking is handled elsewhere; reaction ends at once
			ST_FAULT_REACTION:
				next_state = ST_FAULT;
			ST_FAULT:
				if (fault_reset_edge)
					next_state = ST_SWITCH_ON_DISABLED;
			default:
				next_state = ST_NOT_READY;
		endcase
		// Faults outrank commands; fatal outranks everything
		if (fault_in && state != ST_SELF_TEST && state != ST_NOT_READY
			&& state != ST_FAULT_REACTION && state != ST_FAULT)
			next_state = ST_FAULT_REACTION;
		if (fatal_in)
			next_state = ST_NOT_READY;
	end

	always_comb begin
		case (next_state)
			ST_SWITCH_ON_DISABLED: next_state_word = SW_SWITCH_ON_DIS;
			ST_READY:              next_state_word = SW_READY;
			ST_SWITCHED_ON:        next_state_word = SW_SWITCHED_ON;
			ST_OP_ENABLED:         next_state_word = SW_OP_ENABLED;
			ST_QUICK_STOP:         next_state_word = SW_QUICK_STOP;
			ST_FAULT_REACTION:     next_state_word = SW_FAULT_REACTION;
			ST_FAULT:              next_state_word = SW_FAULT;
			default:               next_state_word = SW_NOT_READY;
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			state            <= ST_SELF_TEST;
			POWER_STATE_WORD <= SW_NOT_READY;
			POWER_STAGE_ON   <= 1'b0;
		end else begin
			state            <= next_state;
			POWER_STATE_WORD <= next_state_word;
			POWER_STAGE_ON   <= next_state == ST_OP_ENABLED
				|| next_state == ST_QUICK_STOP;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Object reads, one cycle after the request
	logic [15:0] next_rdata;
	logic        next_rvalid;
	logic        next_err;

	always_comb begin
		next_rdata  = 16'h0000;
		next_rvalid = OBJ_RD;
		next_err    = 1'b0;
		case (OBJ_INDEX)
			IDX_COMMAND_WORD: next_rdata = command_word;
			IDX_STATE_WORD:   next_rdata = POWER_STATE_WORD;
			IDX_MODE_SELECT:  next_rdata = {8'h00, mode_request};
			IDX_MODE_DISPLAY: next_rdata = {8'h00, ACTIVE_MODE};
			default:          next_err   = OBJ_RD || OBJ_WR;
		endcase
		if (OBJ_WR && OBJ_INDEX == IDX_STATE_WORD)
			next_err = 1'b1;
		if (!OBJ_RD)
			next_rdata = 16'h0000;
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			OBJ_RDATA  <= 16'h0000;
			OBJ_RVALID <= 1'b0;
			OBJ_ERR    <= 1'b0;
		end else begin
			OBJ_RDATA  <= next_rdata;
			OBJ_RVALID <= next_rvalid;
			OBJ_ERR    <= next_err;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	logic calm;
	assign calm = !fault_in && !fatal_in;

	sequence s_mode_write;
		OBJ_WR && OBJ_INDEX == IDX_MODE_SELECT;
	endsequence

	sequence s_mode_shown;
		ACTIVE_MODE == $past(OBJ_WDATA[7:0], 2);
	endsequence

	property p_mode_path;
		@(posedge CLOCK) disable iff (SYS_RST)
		s_mode_write ##1 !(OBJ_WR && OBJ_INDEX == IDX_MODE_SELECT)
			|=> s_mode_shown;
	endproperty
	a_mode_path: assert property (p_mode_path)
		else $error("mode display did not follow mode select");

	property p_boot;
		@(posedge CLOCK) disable iff (SYS_RST)
		state == ST_SELF_TEST && test_done && test_ok && !fatal_in
			|=> state == ST_SWITCH_ON_DISABLED
			&& POWER_STATE_WORD == SW_SWITCH_ON_DIS;
	endproperty
	a_boot: assert property (p_boot)
		else $error("self-test pass did not reach switch on disabled");

	property p_dead;
		@(posedge CLOCK) disable iff (SYS_RST)
		state == ST_NOT_READY |=> state == ST_NOT_READY [*8];
	endproperty
	a_dead: assert property (p_dead)
		else $error("left not ready to switch on");

	property p_shutdown;
		@(posedge CLOCK) disable iff (SYS_RST)
		state == ST_SWITCH_ON_DISABLED && cmd_shutdown && calm
			|=> state == ST_READY ##0
			(POWER_STATE_WORD & SW_STATE_MASK) == SW_READY;
	endproperty
	a_shutdown: assert property (p_shutdown)
		else $error("shutdown did not reach ready to switch on");

	property p_quick_stop;
		@(posedge CLOCK) disable iff (SYS_RST)
		state == ST_OP_ENABLED && !b7 && !b2 && b1 && calm
			|=> POWER_STATE_WORD == SW_QUICK_STOP;
	endproperty
	a_quick_stop: assert property (p_quick_stop)
		else $error("quick stop not taken");

	property p_voltage_off;
		@(posedge CLOCK) disable iff (SYS_RST)
		state == ST_OP_ENABLED && !b7 && !b1 && calm
			|=> state == ST_SWITCH_ON_DISABLED;
	endproperty
	a_voltage_off: assert property (p_voltage_off)
		else $error("disable voltage ignored or masked by other bits");

	property p_fault_level;
		@(posedge CLOCK) disable iff (SYS_RST)
		state == ST_FAULT && $past(b7) && b7 && !fatal_in
			|=> state == ST_FAULT;
	endproperty
	a_fault_level: assert property (p_fault_level)
		else $error("fault left on a held reset level");

	property p_fault_edge;
		@(posedge CLOCK) disable iff (SYS_RST)
		state == ST_FAULT && $rose(b7) && !fatal_in
			|=> state == ST_SWITCH_ON_DISABLED;
	endproperty
	a_fault_edge: assert property (p_fault_edge)
		else $error("fault reset edge not taken");

	property p_op_word;
		@(posedge CLOCK) disable iff (SYS_RST)
		state == ST_OP_ENABLED |-> POWER_STATE_WORD == SW_OP_ENABLED
			&& POWER_STAGE_ON;
	endproperty
	a_op_word: assert property (p_op_word)
		else $error("operation enabled word wrong");

endmodule : drive_power_state_machine
`default_nettype wire

/* File: logic/drive_power_pkg.sv */
`default_nettype none
package drive_power_pkg;

	// Object indices on the object access port
	localparam logic [15:0] IDX_COMMAND_WORD = 16'h6040;
	localparam logic [15:0] IDX_STATE_WORD   = 16'h6041;
	localparam logic [15:0] IDX_MODE_SELECT  = 16'h6060;
	localparam logic [15:0] IDX_MODE_DISPLAY = 16'h6061;

	// Command word bit positions
	localparam int CMD_SWITCH_ON   = 0;
	localparam int CMD_VOLTAGE     = 1;
	localparam int CMD_QUICK_STOP  = 2;
	localparam int CMD_ENABLE_OP   = 3;
	localparam int CMD_FAULT_RESET = 7;

	// State word images, bits 6,5,3..0 only
	localparam logic [15:0] SW_NOT_READY      = 16'h0000;
	localparam logic [15:0] SW_SWITCH_ON_DIS  = 16'h0040;
	localparam logic [15:0] SW_READY          = 16'h0021;
	localparam logic [15:0] SW_SWITCHED_ON    = 16'h0023;
	localparam logic [15:0] SW_OP_ENABLED     = 16'h0027;
	localparam logic [15:0] SW_QUICK_STOP     = 16'h0007;
	localparam logic [15:0] SW_FAULT_REACTION = 16'h000f;
	localparam logic [15:0] SW_FAULT          = 16'h0008;
	localparam logic [15:0] SW_STATE_MASK     = 16'h006f;

	// Reset values
	localparam logic [15:0] COMMAND_RESET = 16'h0000;
	localparam logic [7:0]  MODE_RESET    = 8'h00;

	// Pin input positions in the synchroniser vector
	localparam int PIN_TEST_DONE = 0;
	localparam int PIN_TEST_OK   = 1;
	localparam int PIN_FAULT     = 2;
	localparam int PIN_FATAL     = 3;
	localparam int PIN_COUNT     = 4;

	typedef enum logic [3:0] {
		ST_SELF_TEST,
		ST_NOT_READY,
		ST_SWITCH_ON_DISABLED,
		ST_READY,
		ST_SWITCHED_ON,
		ST_OP_ENABLED,
		ST_QUICK_STOP,
		ST_FAULT_REACTION,
		ST_FAULT
	} power_state_e;

endpackage : drive_power_pkg
`default_nettype wire

/* File: sim/fieldbus_master_model.sv */
`timescale 1ns/1ns
`default_nettype none
module fieldbus_master_model
	import drive_power_pkg::*;
(
	input  wire logic        CLOCK,
	input  wire logic [15:0] OBJ_RDATA,
	input  wire logic        OBJ_RVALID,
	input  wire logic        OBJ_ERR,
	output logic             OBJ_WR,
	output logic             OBJ_RD,
	output logic      [15:0] OBJ_INDEX,
	output logic      [15:0] OBJ_WDATA
);
	logic [15:0] rdata;
	logic        rvalid;
	logic        err;

	initial begin
		OBJ_WR = 1'b0;
		OBJ_RD = 1'b0;
		OBJ_INDEX = 16'h0000;
		OBJ_WDATA = 16'h0000;
	end

	////////////////////////////////////////////////////////////////////////
	// One strobe cycle, answer taken at the negedge that ends it
	task automatic access(input logic wr, input logic [15:0] idx,
		input logic [15:0] data);
		@(negedge CLOCK);
		OBJ_WR = wr;
		OBJ_RD = !wr;
		OBJ_INDEX = idx;
		OBJ_WDATA = data;
		@(negedge CLOCK);
		rdata = OBJ_RDATA;
		rvalid = OBJ_RVALID;
		err = OBJ_ERR;
		OBJ_WR = 1'b0;
		OBJ_RD = 1'b0;
		// Idle lines garbage, so a stale value cannot be relied on
		OBJ_INDEX = ~idx;
		OBJ_WDATA = ~data;
	endtask : access
endmodule : fieldbus_master_model
`default_nettype wire

/* File: sim/drive_power_state_machine_test.sv */
`timescale 1ns/1ns
`default_nettype none
module drive_power_state_machine_test;
	import drive_power_pkg::*;
	typedef struct packed {
		logic [15:0] idx;
		logic [15:0] data;
		logic [15:0] exp;
	} row_s;
	localparam logic [15:0] CW = IDX_COMMAND_WORD;
	localparam logic [15:0] MS = IDX_MODE_SELECT;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        done = 1'b0;
	logic        ok = 1'b0;
	logic        fault = 1'b0;
	logic        fatal = 1'b0;
	logic        obj_wr;
	logic        obj_rd;
	logic        obj_rvalid;
	logic        obj_err;
	logic        stage_on;
	logic [15:0] obj_index;
	logic [15:0] obj_wdata;
	logic [15:0] obj_rdata;
	logic [15:0] sw;
	logic [7:0]  mode;
	int          n_mismatch = 0;
	int          checked = 0;
	row_s        rows [25] = '{
		'{CW, 16'h0006, SW_READY},
		'{CW, 16'h0007, SW_SWITCHED_ON},
		'{MS, 16'hab05, 16'h0005},
		'{CW, 16'h000f, SW_OP_ENABLED},
		'{CW, 16'h0007, SW_SWITCHED_ON},
		'{CW, 16'h000f, SW_OP_ENABLED},
		'{MS, 16'h0003, 16'h0003},
		'{CW, 16'h000b, SW_QUICK_STOP},
		'{CW, 16'h000f, SW_OP_ENABLED},
		'{CW, 16'h000b, SW_QUICK_STOP},
		'{CW, 16'h0009, SW_SWITCH_ON_DIS},
		'{CW, 16'hff7e, SW_READY},
		'{CW, 16'h0007, SW_SWITCHED_ON},
		'{CW, 16'h0006, SW_READY},
		'{CW, 16'h0000, SW_SWITCH_ON_DIS},
		'{CW, 16'h0006, SW_READY},
		'{CW, 16'h0007, SW_SWITCHED_ON},
		'{CW, 16'h0005, SW_SWITCH_ON_DIS},
		'{CW, 16'h0006, SW_READY},
		'{CW, 16'h0007, SW_SWITCHED_ON},
		'{CW, 16'h000f, SW_OP_ENABLED},
		'{CW, 16'h0006, SW_READY},
		'{CW, 16'h0007, SW_SWITCHED_ON},
		'{CW, 16'h000f, SW_OP_ENABLED},
		'{CW, 16'h000d, SW_SWITCH_ON_DIS}
	};

	always #25 clock = ~clock;

	drive_power_state_machine uut (
		.CLOCK(clock), .SYS_RST(rst), .OBJ_WR(obj_wr), .OBJ_RD(obj_rd),
		.OBJ_INDEX(obj_index), .OBJ_WDATA(obj_wdata),
		.SELF_TEST_DONE(done), .SELF_TEST_OK(ok), .FAULT_EVENT(fault),
		.FATAL_ERROR(fatal), .OBJ_RDATA(obj_rdata), .OBJ_RVALID(obj_rvalid),
		.OBJ_ERR(obj_err), .POWER_STATE_WORD(sw), .ACTIVE_MODE(mode),
		.POWER_STAGE_ON(stage_on)
	);

	fieldbus_master_model master (
		.CLOCK(clock), .OBJ_RDATA(obj_rdata), .OBJ_RVALID(obj_rvalid),
		.OBJ_ERR(obj_err), .OBJ_WR(obj_wr), .OBJ_RD(obj_rd),
		.OBJ_INDEX(obj_index), .OBJ_WDATA(obj_wdata)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic complete_run;
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Bounded poll; a hang ends the run at once
	task automatic wait_sw(input logic [15:0] exp);
		int n = 0;
		while (sw !== exp && n < 20) begin
			@(negedge clock);
			n++;
		end
		check(sw, exp);
		if (sw !== exp) complete_run();
	endtask : wait_sw

	task automatic do_reset;
		rst = 1'b1;
		repeat (6) @(negedge clock);
		check(sw, SW_NOT_READY);
		rst = 1'b0;
	endtask : do_reset

	////////////////////////////////////////////////////////////////////////
	initial begin
		do_reset();
		done = 1'b1;
		ok = 1'b1;
		wait_sw(SW_SWITCH_ON_DIS);
		foreach (rows[i]) begin
			master.access(1'b1, rows[i].idx, rows[i].data);
			repeat (2) @(negedge clock);
			if (rows[i].idx == CW) check(sw, rows[i].exp);
			else check({8'h00, mode}, rows[i].exp);
			if (rows[i].idx == CW)
				check({15'h0000, stage_on}, {15'h0000, rows[i].exp[2]});
			master.access(1'b0, rows[i].idx + 16'h0001, 16'h0000);
			check(master.rdata, rows[i].exp);
			check({15'h0000, master.err}, 16'h0000);
		end
		check({15'h0000, master.rvalid}, 16'h0001);
		// Readback of the written objects, not only of the displays
		master.access(1'b0, CW, 16'h0000);
		check(master.rdata, 16'h000d);
		master.access(1'b0, MS, 16'h0000);
		check(master.rdata, 16'h0003);
		master.access(1'b1, IDX_STATE_WORD, 16'h0027);
		check({15'h0000, master.err}, 16'h0001);
		master.access(1'b0, 16'h1234, 16'h0000);
		check({15'h0000, master.err}, 16'h0001);
		check(sw, SW_SWITCH_ON_DIS);
		// Bit 7 already high when the fault hits: level must not reset it
		master.access(1'b1, CW, 16'h0080);
		fault = 1'b1;
		wait_sw(SW_FAULT_REACTION);
		@(negedge clock);
		check(sw, SW_FAULT);
		fault = 1'b0;
		repeat (4) @(negedge clock);
		check(sw, SW_FAULT);
		master.access(1'b1, CW, 16'h0000);
		master.access(1'b1, CW, 16'h0080);
		repeat (2) @(negedge clock);
		check(sw, SW_SWITCH_ON_DIS);
		fatal = 1'b1;
		wait_sw(SW_NOT_READY);
		fatal = 1'b0;
		master.access(1'b1, CW, 16'h0006);
		master.access(1'b1, CW, 16'h0000);
		master.access(1'b1, CW, 16'h0080);
		master.access(1'b1, MS, 16'h0009);
		repeat (2) @(negedge clock);
		check(sw, SW_NOT_READY);
		check({8'h00, mode}, 16'h0009);
		// Failed self-test after a second reset never leaves not ready
		done = 1'b0;
		ok = 1'b0;
		do_reset();
		done = 1'b1;
		repeat (8) @(negedge clock);
		check(sw, SW_NOT_READY);
		// A shutdown must not pull it out of not ready either
		master.access(1'b1, CW, 16'h0006);
		repeat (2) @(negedge clock);
		check(sw, SW_NOT_READY);
		complete_run();
	end
endmodule : drive_power_state_machine_test
`default_nettype wire
